// [src/sop_array_pkg.sv]
// package: constants and types shared by the registered sum-of-products array
`default_nettype none
package sop_array_pkg;
  localparam int NUM_OUT       = 8;
  localparam int NUM_DIN       = 12;
  localparam int NUM_COL       = 20;
  localparam int LIT_W         = 40;
  localparam int NUM_TERMS     = 64;
  localparam int TERMS_PER_OUT = 8;
  localparam int CELL_W        = TERMS_PER_OUT * LIT_W;
  localparam int FUSE_W        = NUM_TERMS * LIT_W;
  localparam int NUM_PINS      = NUM_DIN + 2 + NUM_OUT;

  localparam logic [11:0] CTRL_OFS  = 12'h000;
  localparam logic [11:0] POL_OFS   = 12'h004;
  localparam logic [11:0] PMASK_OFS = 12'h008;
  localparam logic [11:0] STATE_OFS = 12'h00C;
  localparam logic [11:0] INFO_OFS  = 12'h010;
  localparam logic [11:0] FUSE_BASE = 12'h100;
  localparam logic [11:0] FUSE_LAST = 12'h2FC;

  localparam int CTRL_PRELOAD_BIT = 0;
  localparam int CTRL_SECURE_BIT  = 1;

  localparam logic [7:0]  POL_RESET   = 8'hFF;
  localparam logic [7:0]  PMASK_RESET = 8'h00;
  localparam logic [7:0]  STATE_RESET = 8'h00;
  localparam logic [39:0] FUSE_RESET  = 40'hFF_FFFF_FFFF;
  localparam logic [31:0] WORD_ONES   = 32'hFFFF_FFFF;
  localparam logic [7:0]  BYTE_ONES   = 8'hFF;

  typedef enum logic [1:0] {
    VAR_COMB = 2'h0,
    VAR_R8   = 2'h1,
    VAR_R6   = 2'h2,
    VAR_R4   = 2'h3
  } variant_type;

  typedef enum logic [3:0] {
    BUS_IDLE    = 4'h1,
    BUS_WRITE   = 4'h2,
    BUS_RD_WAIT = 4'h4,
    BUS_RD_DONE = 4'h8
  } bus_state_type;

  // registered outputs sit in the middle of the output row, except that VAR_R8 registers all eight
  function automatic logic [7:0] reg_mask(input variant_type v);
    case (v)
      VAR_R8:  reg_mask = 8'hFF;
      VAR_R6:  reg_mask = 8'h7E;
      VAR_R4:  reg_mask = 8'h3C;
      default: reg_mask = 8'h00;
    endcase
  endfunction: reg_mask
endpackage: sop_array_pkg
`default_nettype wire

// [src/fuse_store.sv]
// module: fuse map of the and array, one word per product term
`default_nettype none
module fuse_store (
  input  wire logic                              hclk,
  input  wire logic                              hresetn,
  input  wire logic                              we,
  input  wire logic [5:0]                        wr_term,
  input  wire logic                              wr_hi,
  input  wire logic [31:0]                       wr_data,
  input  wire logic                              rd_en,
  input  wire logic [5:0]                        rd_term,
  output logic      [sop_array_pkg::LIT_W-1:0]   rd_data_q,
  output logic      [sop_array_pkg::FUSE_W-1:0]  fuses
);
  // a write can only open links; a blown fuse is restored only by reset
  logic [sop_array_pkg::LIT_W-1:0] blow_mask;
  assign blow_mask = wr_hi ? {wr_data[7:0], sop_array_pkg::WORD_ONES}
                           : {sop_array_pkg::BYTE_ONES, wr_data};

  for (genvar g = 0; g < sop_array_pkg::NUM_TERMS; g++) begin : g_word
    logic [sop_array_pkg::LIT_W-1:0] word_q;
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        word_q <= sop_array_pkg::FUSE_RESET;
      end else if (we && wr_term == 6'(g)) begin
        word_q <= word_q & blow_mask;
      end
    end
    assign fuses[g*sop_array_pkg::LIT_W +: sop_array_pkg::LIT_W] = word_q;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rd_data_q <= '0;
    end else if (rd_en) begin
      rd_data_q <= fuses[rd_term*sop_array_pkg::LIT_W +: sop_array_pkg::LIT_W];
    end
  end
endmodule: fuse_store
`default_nettype wire

// [src/sop_cell.sv]
// module: eight product terms and the fixed or gate of one output
`default_nettype none
module sop_cell (
  input  wire logic [sop_array_pkg::CELL_W-1:0] fuses,
  input  wire logic [sop_array_pkg::LIT_W-1:0]  lits,
  input  wire logic                             registered,
  output logic                                  sum,
  output logic                                  enable_term
);
  logic [sop_array_pkg::TERMS_PER_OUT-1:0] terms;

  // an intact link ties its literal into the and; all intact gives x & ~x
  for (genvar j = 0; j < sop_array_pkg::TERMS_PER_OUT; j++) begin : g_term
    assign terms[j] = &(lits | ~fuses[j*sop_array_pkg::LIT_W +: sop_array_pkg::LIT_W]);
  end

  // combinational outputs spend their first term on the enable
  assign sum         = registered ? |terms : |terms[7:1];
  assign enable_term = terms[0];
endmodule: sop_cell
`default_nettype wire

// [src/sop_array.sv]
// module: registered sum-of-products array with ahb-lite fuse access
//
// Implementation choices: register access over AHB-Lite and the placing of the registers.
`default_nettype none
module sop_array #(
  parameter sop_array_pkg::variant_type VARIANT = sop_array_pkg::VAR_R8
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic      [31:0] hrdata,
  output logic             hresp,
  input  wire logic [11:0] in_pin,
  input  wire logic        clk_pin,
  input  wire logic        oe_n_pin,
  input  wire logic [7:0]  out_i,
  output logic      [7:0]  out_o,
  output logic      [7:0]  out_oe
);
  localparam logic [7:0] REGM = sop_array_pkg::reg_mask(VARIANT);
  localparam logic       IS_COMB = (VARIANT == sop_array_pkg::VAR_COMB);

  // pin synchronisers
  logic [sop_array_pkg::NUM_PINS-1:0] pin_meta_q;
  logic [sop_array_pkg::NUM_PINS-1:0] pin_sync_q;
  logic                               clk_prev_q;
  logic [11:0]                        din;
  logic                               clk_s;
  logic                               oe_n_s;
  logic [7:0]                         fb_pin;
  logic                               clk_rise;

  // array
  logic [sop_array_pkg::NUM_COL-1:0]  col;
  logic [sop_array_pkg::LIT_W-1:0]    lit;
  logic [sop_array_pkg::FUSE_W-1:0]   fuses;
  logic [7:0]                         sum;
  logic [7:0]                         en_term;
  logic [7:0]                         q_q;
  logic [7:0]                         q_d;

  // software state
  logic                               preload_q;
  logic                               secure_q;
  logic [7:0]                         pol_q;
  logic [7:0]                         pmask_q;

  // bus
  sop_array_pkg::bus_state_type       state_q;
  logic [11:0]                        addr_q;
  logic                               accept;
  logic                               wr_fire;
  logic                               rd_fire;
  logic                               is_fuse;
  logic [11:0]                        fuse_ofs;
  logic [39:0]                        fuse_rd;
  logic [31:0]                        reg_rd;
  logic [31:0]                        rd_reg_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_meta_q <= '0;
      pin_sync_q <= '0;
      clk_prev_q <= 1'b0;
    end else begin
      pin_meta_q <= {out_i, oe_n_pin, clk_pin, in_pin};
      pin_sync_q <= pin_meta_q;
      clk_prev_q <= pin_sync_q[12];
    end
  end

  assign din      = pin_sync_q[11:0];
  assign clk_s    = pin_sync_q[12];
  assign oe_n_s   = pin_sync_q[13];
  assign fb_pin   = pin_sync_q[21:14];
  assign clk_rise = clk_s & ~clk_prev_q;

  // columns 0..11 dedicated inputs, 12..19 one feedback per output, except that the combinational variant puts clk_s on 12 and oe_n_s on 19
  assign col[11:0] = din;
  for (genvar k = 0; k < sop_array_pkg::NUM_OUT; k++) begin : g_out
    if (IS_COMB && k == 0) begin : g_in12
      assign col[12+k] = clk_s;
    end else if (IS_COMB && k == 7) begin : g_in13
      assign col[12+k] = oe_n_s;
    end else if (REGM[k]) begin : g_regfb
      assign col[12+k] = q_q[k];
    end else begin : g_pinfb
      // a pin whose enable term stays false acts as a plain input
      assign col[12+k] = fb_pin[k];
    end

    sop_cell u_cell (
      .fuses       (fuses[k*sop_array_pkg::CELL_W +: sop_array_pkg::CELL_W]),
      .lits        (lit),
      .registered  (REGM[k]),
      .sum         (sum[k]),
      .enable_term (en_term[k])
    );

    // polarity fuse; a set pol_q bit makes a registered pin invert its flip-flop state and a combinational pin pass its sum
    assign out_o[k] = REGM[k] ? (pol_q[k] ? ~q_q[k] : q_q[k])
                              : (pol_q[k] ? sum[k] : ~sum[k]);
    // preload floats registered pins so the tester can drive them
    assign out_oe[k] = REGM[k] ? (~oe_n_s & ~preload_q)
                               : en_term[k];
  end

  for (genvar c = 0; c < sop_array_pkg::NUM_COL; c++) begin : g_lit
    assign lit[2*c]   = col[c];
    assign lit[2*c+1] = ~col[c];
  end

  // output registers
  always_comb begin
    q_d = q_q;
    if (clk_rise) begin
      if (preload_q) begin
        // the pin level is the image the register will show afterwards
        q_d = (q_q & ~pmask_q) | (pmask_q & (pol_q ~^ ~fb_pin));
      end else begin
        q_d = sum;
      end
    end
    q_d = q_d & REGM;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      q_q <= sop_array_pkg::STATE_RESET;
    end else begin
      q_q <= q_d;
    end
  end

  // ahb-lite slave: reads take one wait state for the fuse read port
  assign accept   = hsel & htrans[1] & hready;
  assign wr_fire  = (state_q == sop_array_pkg::BUS_WRITE);
  assign rd_fire  = (state_q == sop_array_pkg::BUS_RD_WAIT);
  assign fuse_ofs = addr_q - sop_array_pkg::FUSE_BASE;
  assign is_fuse  = (addr_q >= sop_array_pkg::FUSE_BASE) &&
                    (addr_q <= sop_array_pkg::FUSE_LAST);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_q <= sop_array_pkg::BUS_IDLE;
    end else begin
      case (state_q)
        sop_array_pkg::BUS_RD_WAIT: begin
          state_q <= sop_array_pkg::BUS_RD_DONE;
        end
        sop_array_pkg::BUS_IDLE,
        sop_array_pkg::BUS_WRITE,
        sop_array_pkg::BUS_RD_DONE: begin
          if (accept) begin
            state_q <= hwrite ? sop_array_pkg::BUS_WRITE : sop_array_pkg::BUS_RD_WAIT;
          end else begin
            state_q <= sop_array_pkg::BUS_IDLE;
          end
        end
        default: begin
          state_q <= sop_array_pkg::BUS_IDLE;
        end
      endcase
    end
  end

  // upper address bits are not decoded, so the map repeats every 4 KiB
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      addr_q <= '0;
    end else if (accept) begin
      addr_q <= {haddr[11:2], 2'b00};
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      preload_q <= 1'b0;
      secure_q  <= 1'b0;
    end else if (wr_fire && addr_q == sop_array_pkg::CTRL_OFS) begin
      preload_q <= hwdata[sop_array_pkg::CTRL_PRELOAD_BIT];
      // protection can only be set; only reset clears it
      secure_q  <= secure_q | hwdata[sop_array_pkg::CTRL_SECURE_BIT];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pol_q <= sop_array_pkg::POL_RESET;
    end else if (wr_fire && addr_q == sop_array_pkg::POL_OFS) begin
      pol_q <= hwdata[7:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pmask_q <= sop_array_pkg::PMASK_RESET;
    end else if (wr_fire && addr_q == sop_array_pkg::PMASK_OFS) begin
      pmask_q <= hwdata[7:0] & REGM;
    end
  end

  fuse_store u_fuses (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .we        (wr_fire & is_fuse),
    .wr_term   (fuse_ofs[8:3]),
    .wr_hi     (fuse_ofs[2]),
    .wr_data   (hwdata),
    .rd_en     (rd_fire & is_fuse),
    .rd_term   (fuse_ofs[8:3]),
    .rd_data_q (fuse_rd),
    .fuses     (fuses)
  );

  always_comb begin
    reg_rd = '0;
    case (addr_q)
      sop_array_pkg::CTRL_OFS:  reg_rd = {30'h0000_0000, secure_q, preload_q};
      sop_array_pkg::POL_OFS:   reg_rd = {24'h00_0000, pol_q};
      sop_array_pkg::PMASK_OFS: reg_rd = {24'h00_0000, pmask_q};
      sop_array_pkg::STATE_OFS: reg_rd = {8'h00, out_oe, out_o, q_q};
      sop_array_pkg::INFO_OFS:  reg_rd = {16'h0000, REGM, 6'h00, VARIANT};
      default:                  reg_rd = '0;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rd_reg_q <= '0;
    end else if (rd_fire) begin
      rd_reg_q <= reg_rd;
    end
  end

  always_comb begin
    hrdata = '0;
    if (state_q == sop_array_pkg::BUS_RD_DONE) begin
      if (!is_fuse) begin
        hrdata = rd_reg_q;
      end else if (!secure_q) begin
        hrdata = fuse_ofs[2] ? {24'h00_0000, fuse_rd[39:32]} : fuse_rd[31:0];
      end
    end
  end

  assign hreadyout = (state_q != sop_array_pkg::BUS_RD_WAIT);
  assign hresp     = 1'b0;

  // checks
  a_reg_capture: assert property (@(posedge hclk) disable iff (!hresetn)
    clk_rise && !preload_q |=> (q_q & REGM) == ($past(sum) & REGM))
    else $error("register did not capture its sum on clock rise");

  a_reg_hold: assert property (@(posedge hclk) disable iff (!hresetn)
    !clk_rise |=> q_q == $past(q_q))
    else $error("register changed without a clock rise");

  a_reg_enable: assert property (@(posedge hclk) disable iff (!hresetn)
    ##2 ((out_oe & REGM) == ((!$past(oe_n_pin, 2) && !preload_q) ? REGM : 8'h00)))
    else $error("registered enables do not follow the enable pin");

  a_comb_enable: assert property (@(posedge hclk) disable iff (!hresetn)
    ((out_oe & ~REGM) == (en_term & ~REGM)))
    else $error("combinational output driven without its enable term");

  a_pin_invert: assert property (@(posedge hclk) disable iff (!hresetn)
    ((out_o & REGM & pol_q) == (~q_q & REGM & pol_q)))
    else $error("registered pin is not the complement of its state");

  a_feedback_path: assert property (@(posedge hclk) disable iff (!hresetn)
    ((col[19:12] & REGM) == (q_q & REGM)))
    else $error("register state missing from array feedback");

  a_reset_clear: assert property (@(posedge hclk)
    $rose(hresetn) |-> (q_q == 8'h00) && ((out_o & REGM) == REGM))
    else $error("registers not clear after power-on");

  a_virgin_off: assert property (@(posedge hclk)
    $rose(hresetn) |-> (sum == 8'h00) && (en_term == 8'h00) && (pol_q == 8'hFF))
    else $error("virgin array has an active term");

  a_secure_read: assert property (@(posedge hclk) disable iff (!hresetn)
    state_q == sop_array_pkg::BUS_RD_DONE && is_fuse && secure_q |-> hrdata == 32'h0000_0000)
    else $error("protected fuse map was read back");

  a_preload_load: assert property (@(posedge hclk) disable iff (!hresetn)
    clk_rise && preload_q |=>
      (q_q & $past(pmask_q)) == ($past(pol_q ~^ ~fb_pin) & $past(pmask_q)))
    else $error("preload did not take the pin level");

  a_read_wait: assert property (@(posedge hclk) disable iff (!hresetn)
    accept && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read wait state is not exactly one cycle");

  c_preload: cover property (@(posedge hclk) disable iff (!hresetn)
    clk_rise && preload_q && pmask_q != 8'h00);
  c_fuse_write: cover property (@(posedge hclk) disable iff (!hresetn)
    wr_fire && is_fuse);
  c_clocked_drive: cover property (@(posedge hclk) disable iff (!hresetn)
    clk_rise && !preload_q && (out_oe & REGM) != 8'h00);
  c_comb_drive: cover property (@(posedge hclk) disable iff (!hresetn)
    (out_oe & ~REGM) != 8'h00);
endmodule: sop_array
`default_nettype wire

// [test/board_model.sv]
// board model: clock pulses and pin resolution around the array
`default_nettype none
module board_model (
  input  wire logic       hclk,
  input  wire logic       pulse_req,
  input  wire logic [7:0] ext_val,
  input  wire logic [7:0] ext_en,
  input  wire logic [7:0] out_o,
  input  wire logic [7:0] out_oe,
  output logic            clk_pin,
  output logic            pulse_busy,
  output logic [7:0]      out_i
);
  timeunit 1ns;
  timeprecision 100ps;
  logic       req_q = 1'b0;
  logic [3:0] cnt_q = 4'h0;
  logic [7:0] last_q = 8'h00;
  // clock stands low between pulses: four cycles high, four low
  always_ff @(posedge hclk) begin
    if (req_q != pulse_req) begin
      req_q <= pulse_req;
      cnt_q <= 4'h8;
    end else if (cnt_q != 4'h0) begin
      cnt_q <= cnt_q - 4'h1;
    end
  end
  assign clk_pin    = (cnt_q > 4'h4);
  assign pulse_busy = (req_q != pulse_req) || (cnt_q != 4'h0);
  // floating pin settles at the inverse of its last driven level, so stale data never passes
  always_comb begin
    for (int k = 0; k < 8; k++) begin
      out_i[k] = out_oe[k] ? out_o[k] : (ext_en[k] ? ext_val[k] : ~last_q[k]);
    end
  end
  // only a driven level is remembered; a floating pin must not toggle by itself
  always_ff @(posedge hclk) begin
    for (int k = 0; k < 8; k++) begin
      if (out_oe[k] || ext_en[k]) begin
        last_q[k] <= out_i[k];
      end
    end
  end
endmodule: board_model
`default_nettype wire

// [test/registered_sop_logic_array_bench.sv]
// testbench: bus and pin scenarios for the registered sum-of-products array
`default_nettype none
module registered_sop_logic_array_bench;
  timeunit 1ns;
  timeprecision 100ps;
  logic        hclk;
  logic        hresetn;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic        hreadyout;
  logic        r4_rdy;
  logic        sel_r4;
  logic        hrdy;
  logic [31:0] hrd;
  logic [31:0] r4_rdata;
  logic [31:0] hrdata;
  logic [11:0] in_pin;
  logic        oe_n_pin;
  logic        clk_pin;
  logic [7:0]  out_i;
  logic [7:0]  out_o;
  logic [7:0]  out_oe;
  logic [7:0]  r4_o;
  logic [7:0]  r4_oe;
  logic [7:0]  ext_val;
  logic [7:0]  ext_en;
  logic        pulse_req;
  logic        pulse_busy;
  int          fail_count;
  int          total_checks;
  logic [31:0] rd;

  sop_array #(.VARIANT(sop_array_pkg::VAR_R8)) i_dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel & ~sel_r4), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hrdy),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(), .in_pin(in_pin),
    .clk_pin(clk_pin), .oe_n_pin(oe_n_pin), .out_i(out_i), .out_o(out_o), .out_oe(out_oe));
  // second variant: watched at its pins; its combinational output 0 gets an enable term
  sop_array #(.VARIANT(sop_array_pkg::VAR_R4)) i_dut_r4 (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel & sel_r4), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hrdy),
    .hreadyout(r4_rdy), .hrdata(r4_rdata), .hresp(), .in_pin(in_pin),
    .clk_pin(clk_pin), .oe_n_pin(oe_n_pin), .out_i(out_i), .out_o(r4_o), .out_oe(r4_oe));
  // one master, two slaves: ready and read data follow the selected slave
  assign hrdy = sel_r4 ? r4_rdy : hreadyout;
  assign hrd  = sel_r4 ? r4_rdata : hrdata;
  board_model i_board (
    .hclk(hclk), .pulse_req(pulse_req), .ext_val(ext_val), .ext_en(ext_en),
    .out_o(out_o), .out_oe(out_oe), .clk_pin(clk_pin), .pulse_busy(pulse_busy),
    .out_i(out_i));

  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end

  task automatic conclude();
    $display("checks %0d failures %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask: conclude

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask: chk

  task automatic idle(input int n);
    repeat (n) @(posedge hclk);
    @(negedge hclk);
  endtask: idle

  // ready and data sampled mid-cycle, so they are the values standing at the edge
  task automatic wait_rdy(output logic [31:0] d);
    logic r;
    int   n;
    n = 0;
    do begin
      @(negedge hclk);
      r = hrdy;
      d = hrd;
      @(posedge hclk);
      n++;
    end while (r !== 1'b1 && n < 20);
    if (r !== 1'b1) begin
      fail_count++;
      $display("[FAIL] %0t bus never ready", $time);
    end
  endtask: wait_rdy

  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] wd);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'b10;
    hwrite <= w;
    wait_rdy(rd);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    wait_rdy(rd);
  endtask: bus

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask: wr

  task automatic rchk(input logic [31:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0000_0000);
    chk(rd, exp);
  endtask: rchk

  task automatic pulse();
    int n;
    repeat (4) @(posedge hclk);
    pulse_req <= ~pulse_req;
    n = 0;
    do begin
      @(negedge hclk);
      n++;
    end while (pulse_busy === 1'b1 && n < 30);
    if (pulse_busy !== 1'b0) begin
      fail_count++;
      $display("[FAIL] %0t clock pulse never ended", $time);
    end
    idle(3);
  endtask: pulse

  initial begin
    repeat (5000) @(posedge hclk);
    fail_count++;
    conclude();
  end

  initial begin
    fail_count = 0;
    total_checks = 0;
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0000_0000;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = 32'h0000_0000;
    in_pin = 12'h000;
    oe_n_pin = 1'b0;
    ext_val = 8'h00;
    ext_en = 8'h00;
    pulse_req = 1'b0;
    sel_r4 = 1'b0;
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    idle(1);
    chk(32'(out_o), 32'h0000_00FF);
    chk(32'(out_oe), 32'h0000_00FF);
    chk(32'(r4_oe), 32'h0000_003C);
    chk(32'(r4_o & 8'h3C), 32'h0000_003C);
    rchk(32'h0000_0004, 32'h0000_00FF);
    rchk(32'h0000_0008, 32'h0000_0000);
    rchk(32'h0000_0010, 32'h0000_FF01);
    rchk(32'h0000_000C, 32'h00FF_FF00);
    rchk(32'h0000_0020, 32'h0000_0000);
    rchk(32'h0000_0100, 32'hFFFF_FFFF);
    rchk(32'h0000_0104, 32'h0000_00FF);
    // four-register part: enable term of output 0 becomes input 0
    sel_r4 <= 1'b1;
    wr(32'h0000_0100, 32'h0000_0001);
    wr(32'h0000_0104, 32'h0000_0000);
    rchk(32'h0000_0010, 32'h0000_3C03);
    sel_r4 <= 1'b0;
    // output 0 follows input 0, output 1 follows register 0
    wr(32'h0000_0100, 32'h0000_0001);
    wr(32'h0000_0104, 32'h0000_0000);
    wr(32'h0000_0140, 32'h0100_0000);
    wr(32'h0000_0144, 32'h0000_0000);
    rchk(32'h0000_0100, 32'h0000_0001);
    in_pin <= 12'h001;
    oe_n_pin <= 1'b1;
    pulse();
    chk(32'(out_oe), 32'h0000_0000);
    chk(32'(r4_oe), 32'h0000_0001);
    rchk(32'h0000_000C, 32'h0000_FE01);
    in_pin <= 12'h000;
    oe_n_pin <= 1'b0;
    pulse();
    chk(32'(out_o), 32'h0000_00FD);
    chk(32'(r4_oe), 32'h0000_003C);
    rchk(32'h0000_000C, 32'h00FF_FD02);
    wr(32'h0000_0004, 32'h0000_00FE);
    idle(2);
    chk(32'(out_o), 32'h0000_00FC);
    wr(32'h0000_0004, 32'h0000_00FF);
    wr(32'h0000_0000, 32'h0000_0001);
    wr(32'h0000_0008, 32'h0000_0080);
    ext_en <= 8'h80;
    idle(3);
    chk(32'(out_oe), 32'h0000_0000);
    pulse();
    @(posedge hclk);
    ext_en <= 8'h00;
    wr(32'h0000_0000, 32'h0000_0000);
    rchk(32'h0000_000C, 32'h00FF_7D82);
    wr(32'h0000_0000, 32'h0000_0002);
    rchk(32'h0000_0100, 32'h0000_0000);
    @(posedge hclk);
    hresetn <= 1'b0;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    rchk(32'h0000_000C, 32'h00FF_FF00);
    rchk(32'h0000_0100, 32'hFFFF_FFFF);
    conclude();
  end
endmodule: registered_sop_logic_array_bench
`default_nettype wire
